// ==== rtl/rtcth_keep.sv ====
// BCD seconds, minutes and hours counter chain with 12/24-hour handling.
`timescale 1ns/1ps
module rtcth_keep
	import rtcth_pkg::*;
(
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Counter access.
	rtcth_time_if.keep tif
);

	typedef struct packed {
		logic [6:0] sec;
		logic [6:0] min;
		logic       pm;
		logic [5:0] hour;
	} rtcth_keep_s;

	rtcth_keep_s r, next_r;
	logic        cy;
	logic [4:0]  t;

	// ==========================================================
	// Counter chain
	always_comb begin
		next_r = r;
		cy = tif.inc;
		t = rtcth_bcd_inc(r.sec[3:0], UNITS_LAST);
		if (cy) next_r.sec[3:0] = t[3:0];
		cy = cy & t[4];
		t = rtcth_bcd_inc({1'b0, r.sec[6:4]}, TENS_LAST);
		if (cy) next_r.sec[6:4] = t[2:0];
		cy = cy & t[4];
		t = rtcth_bcd_inc(r.min[3:0], UNITS_LAST);
		if (cy) next_r.min[3:0] = t[3:0];
		cy = cy & t[4];
		t = rtcth_bcd_inc({1'b0, r.min[6:4]}, TENS_LAST);
		if (cy) next_r.min[6:4] = t[2:0];
		cy = cy & t[4];
		t = rtcth_bcd_inc(r.hour[3:0], UNITS_LAST);
		if (cy) begin
			if (r.hour == (tif.fmt24 ? HOUR24_TOP : HOUR12_TOP)) begin
				next_r.hour = 6'h00;
				next_r.pm = tif.fmt24 ? 1'b0 : ~r.pm;
			end else begin
				next_r.hour[3:0] = t[3:0];
				next_r.hour[5:4] = r.hour[5:4] + {1'b0, t[4]};
				if (tif.fmt24) next_r.pm = 1'b0;
			end
		end
		// A counter write wins over a step in the same cycle.
		if (tif.wr[WR_SEC]) next_r.sec = tif.wdata[6:0];
		if (tif.wr[WR_MIN]) next_r.min = tif.wdata[6:0];
		if (tif.wr[WR_HOUR]) {next_r.pm, next_r.hour} = tif.wdata[6:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= {TIME_RST, TIME_RST, TIME_RST};
		end else begin
			r <= next_r;
		end
	end

	assign tif.sec = r.sec;
	assign tif.min = r.min;
	assign tif.hour = {r.pm, r.hour};

endmodule

// ==== rtl/rtcth_pkg.sv ====
// Constants, types and helpers shared by the time-of-day counter block.
package rtcth_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned SEC_TIME_MS  = 1000;
	localparam int unsigned BUSY_TIME_MS = 4;
	localparam int unsigned SEC_CYCLES   = SEC_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned BUSY_CYCLES  = BUSY_TIME_MS * (CLK_HZ / 1000);
	localparam int          SEC_W        = 26;
	localparam int          BUSY_W       = 18;

	// ==========================================================
	// Register map
	localparam int          APB_AW    = 17;
	localparam logic [15:0] IDX_CTRL0 = 16'h5142;
	localparam logic [15:0] IDX_CTRL1 = 16'h5143;
	localparam logic [15:0] IDX_SEC   = 16'h5144;
	localparam logic [15:0] IDX_MIN   = 16'h5145;
	localparam logic [15:0] IDX_HOUR  = 16'h5146;
	localparam int SRST_BIT = 0;
	localparam int FMT_BIT  = 4;
	localparam int HOLD_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int SNAP_BIT = 2;
	localparam int WR_SEC   = 0;
	localparam int WR_MIN   = 1;
	localparam int WR_HOUR  = 2;
	localparam logic [6:0] TIME_RST = 7'h00;

	// ==========================================================
	// Digit limits
	localparam logic [3:0] UNITS_LAST = 4'h9;
	localparam logic [3:0] TENS_LAST  = 4'h5;
	localparam logic [5:0] HOUR24_TOP = 6'h23;
	localparam logic [5:0] HOUR12_TOP = 6'h11;

	typedef enum logic [2:0] {
		SEL_NONE  = 3'h0,
		SEL_CTRL0 = 3'h1,
		SEL_CTRL1 = 3'h2,
		SEL_SEC   = 3'h3,
		SEL_MIN   = 3'h4,
		SEL_HOUR  = 3'h5
	} rtcth_sel_e;

	typedef enum logic [1:0] {
		CARRY_IDLE = 2'h1,
		CARRY_BUSY = 2'h2
	} rtcth_carry_e;

	// Byte address of a register word: four times its index.
	function automatic logic [APB_AW-1:0] rtcth_addr(logic [15:0] idx);
		return {idx[14:0], 2'h0};
	endfunction

	// BCD digit step; bit 4 of the result is the carry out.
	function automatic logic [4:0] rtcth_bcd_inc(logic [3:0] d,
		logic [3:0] last);
		if (d >= last) begin
			return 5'h10;
		end
		return {1'b0, d + 4'h1};
	endfunction

endpackage

// ==== rtl/rtcth_tick.sv ====
// Sub-second divider that issues a one-cycle pulse once per second.
`timescale 1ns/1ps
module rtcth_tick
	import rtcth_pkg::*;
#(
	parameter int unsigned PERIOD = SEC_CYCLES
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Divider control.
	input  wire logic clr,
	output logic      tick
);

	typedef struct packed {
		logic [SEC_W-1:0] cnt;
		logic             tick;
	} rtcth_tick_s;

	rtcth_tick_s r, next_r;

	// ==========================================================
	// Divider
	// The divider ignores the counter hold so the second keeps its phase.
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (clr) begin
			next_r.cnt = '0;
		end else if (r.cnt == SEC_W'(PERIOD - 1)) begin
			next_r.cnt = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + SEC_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick = r.tick;

endmodule

// ==== rtl/rtcth_time_if.sv ====
// Interface between the control logic and the time counter chain.
`timescale 1ns/1ps
interface rtcth_time_if;
	logic       inc;
	logic [2:0] wr;
	logic [7:0] wdata;
	logic       fmt24;
	logic [6:0] sec;
	logic [6:0] min;
	logic [6:0] hour;
	modport ctrl (output inc, wr, wdata, fmt24, input sec, min, hour);
	modport keep (input inc, wr, wdata, fmt24, output sec, min, hour);
endinterface

// ==== rtl/rtcth_top.sv ====
// Time-of-day counters with hold, busy flag and read snapshot on APB.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module rtcth_top
	import rtcth_pkg::*;
#(
	parameter int unsigned SEC_PERIOD  = SEC_CYCLES,
	parameter int unsigned BUSY_PERIOD = BUSY_CYCLES
) (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB request.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	// APB answer.
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr
);

	typedef struct packed {
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              srst;
		logic              fmt24;
		logic              snap_en;
		logic              hold;
		logic              pend;
		rtcth_carry_e      carry;
		logic [BUSY_W-1:0] busy_cnt;
		logic              inc;
		logic [2:0]        wr;
		logic [7:0]        wdata;
		logic [6:0]        buf_sec;
		logic [6:0]        buf_min;
		logic [6:0]        buf_hour;
	} rtcth_ctl_s;

	rtcth_ctl_s   r;
	rtcth_ctl_s   next_r;
	rtcth_sel_e   sel;
	logic         tick;
	logic         busy;
	logic         start;
	logic         acc_wr;
	logic         setup;
	logic [7:0]   rbyte;

	rtcth_time_if tif ();

	// ==========================================================
	// Address decode
	// Only whole-word addresses match; anything else is answered with
	// an error and reads as zero.
	function automatic rtcth_sel_e rtcth_decode(logic [APB_AW-1:0] a);
		if (a == rtcth_addr(IDX_CTRL0)) begin
			return SEL_CTRL0;
		end else if (a == rtcth_addr(IDX_CTRL1)) begin
			return SEL_CTRL1;
		end else if (a == rtcth_addr(IDX_SEC)) begin
			return SEL_SEC;
		end else if (a == rtcth_addr(IDX_MIN)) begin
			return SEL_MIN;
		end else if (a == rtcth_addr(IDX_HOUR)) begin
			return SEL_HOUR;
		end
		return SEL_NONE;
	endfunction

	assign sel = rtcth_decode(paddr);
	assign busy = (r.carry == CARRY_BUSY);
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && r.pready && pwrite;

	// ==========================================================
	// Submodules
	rtcth_tick #(
		.PERIOD (SEC_PERIOD)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (r.srst),
		.tick    (tick)
	);

	rtcth_keep u_keep (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (tif.keep)
	);

	assign tif.inc = r.inc;
	assign tif.wr = r.wr;
	assign tif.wdata = r.wdata;
	assign tif.fmt24 = r.fmt24;

	// ==========================================================
	// Read data
	// Reserved bits are tied to zero here rather than stored.
	always_comb begin
		rbyte = 8'h00;
		if (sel == SEL_CTRL0) begin
			rbyte[SRST_BIT] = r.srst;
			rbyte[FMT_BIT] = r.fmt24;
		end else if (sel == SEL_CTRL1) begin
			rbyte[SNAP_BIT] = r.snap_en;
			rbyte[BUSY_BIT] = busy;
			rbyte[HOLD_BIT] = r.hold;
		end else if (sel == SEL_SEC) begin
			rbyte[6:0] = r.snap_en ? r.buf_sec : tif.sec;
		end else if (sel == SEL_MIN) begin
			rbyte[6:0] = r.snap_en ? r.buf_min : tif.min;
		end else if (sel == SEL_HOUR) begin
			rbyte[6:0] = r.snap_en ? r.buf_hour : tif.hour;
		end
	end

	// ==========================================================
	// Control
	always_comb begin
		next_r = r;
		start = 1'b0;
		next_r.inc = 1'b0;
		next_r.wr = 3'h0;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;

		// Busy window countdown after each carry.
		case (r.carry)
			CARRY_BUSY: begin
				if (r.busy_cnt == '0) begin
					next_r.carry = CARRY_IDLE;
				end else begin
					next_r.busy_cnt = r.busy_cnt - BUSY_W'(1);
				end
			end
			default: begin
				next_r.carry = CARRY_IDLE;
			end
		endcase

		// The second tick is swallowed while held; only one is remembered.
		if (tick && !r.srst) begin
			if (r.hold) begin
				next_r.pend = 1'b1;
			end else begin
				start = 1'b1;
			end
		end

		// Setup phase: the answer is registered and shown in the access phase.
		if (setup) begin
			next_r.pready = 1'b1;
			next_r.pslverr = (sel == SEL_NONE);
			next_r.prdata = {24'h000000, rbyte};
		end

		// Access phase: a control write takes effect at the completing edge, a counter write one edge later.
		if (acc_wr) begin
			if (sel == SEL_CTRL0) begin
				next_r.srst = pwdata[SRST_BIT];
				next_r.fmt24 = pwdata[FMT_BIT];
			end else if (sel == SEL_CTRL1) begin
				if (pwdata[SNAP_BIT] && !r.snap_en) begin
					next_r.buf_sec = tif.sec;
					next_r.buf_min = tif.min;
					next_r.buf_hour = tif.hour;
				end
				next_r.snap_en = pwdata[SNAP_BIT];
				if (pwdata[HOLD_BIT]) begin
					// A hold request racing a carry loses to it.
					if (!busy && !start) begin
						next_r.hold = 1'b1;
					end
				end else if (r.hold) begin
					next_r.hold = 1'b0;
					if (r.pend || tick) begin
						start = 1'b1;
					end
					next_r.pend = 1'b0;
				end
			end else if (sel == SEL_SEC) begin
				next_r.wr[WR_SEC] = 1'b1;
				next_r.wdata = pwdata[7:0];
			end else if (sel == SEL_MIN) begin
				next_r.wr[WR_MIN] = 1'b1;
				next_r.wdata = pwdata[7:0];
			end else if (sel == SEL_HOUR) begin
				next_r.wr[WR_HOUR] = 1'b1;
				next_r.wdata = pwdata[7:0];
			end
		end

		// Every carry, including a catch-up one, opens a busy window.
		if (start) begin
			next_r.inc = 1'b1;
			next_r.carry = CARRY_BUSY;
			next_r.busy_cnt = BUSY_W'(BUSY_PERIOD - 1);
		end

		// Soft reset holds the control bits at their reset values but
		// leaves the time counters alone.
		if (next_r.srst) begin
			next_r.snap_en = 1'b0;
			next_r.hold = 1'b0;
			next_r.pend = 1'b0;
			next_r.fmt24 = 1'b0;
			next_r.carry = CARRY_IDLE;
			next_r.busy_cnt = '0;
			next_r.inc = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.carry <= CARRY_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic hold_req;
	logic rel_req;
	assign hold_req = acc_wr && sel == SEL_CTRL1 && pwdata[HOLD_BIT];
	assign rel_req = acc_wr && sel == SEL_CTRL1 && !pwdata[HOLD_BIT];

	property p_busy_window;
		tick && !r.hold && !r.srst && !next_r.srst
			|=> busy && r.inc
			&& r.busy_cnt == BUSY_W'(BUSY_PERIOD - 1);
	endproperty
	a_busy_window: assert property (p_busy_window)
		else $error("carry did not open a full busy window");

	property p_busy_ends;
		busy && r.busy_cnt == '0 && !tick && !rel_req |=> !busy;
	endproperty
	a_busy_ends: assert property (p_busy_ends)
		else $error("busy flag outlived its window");

	property p_hold_ignored;
		hold_req && busy && !r.hold |=> !r.hold;
	endproperty
	a_hold_ignored: assert property (p_hold_ignored)
		else $error("hold accepted during a carry");

	property p_hold_quiet;
		r.hold |-> !busy && !r.inc;
	endproperty
	a_hold_quiet: assert property (p_hold_quiet)
		else $error("counters moved or busy set while held");

	property p_hold_blocks;
		r.hold && tick && !rel_req && !next_r.srst
			|=> r.pend && !r.inc ##1 !r.inc;
	endproperty
	a_hold_blocks: assert property (p_hold_blocks)
		else $error("second carry reached counters during hold");

	property p_catch_up;
		rel_req && r.hold && r.pend && !next_r.srst
			|=> r.inc && !r.pend && !r.hold ##1 !r.inc;
	endproperty
	a_catch_up: assert property (p_catch_up)
		else $error("missed second not added exactly once on release");

	property p_snap_copy;
		acc_wr && sel == SEL_CTRL1 && pwdata[SNAP_BIT] && !r.snap_en
			&& !next_r.srst
			|=> r.snap_en && r.buf_sec == $past(tif.sec)
			&& r.buf_hour == $past(tif.hour);
	endproperty
	a_snap_copy: assert property (p_snap_copy)
		else $error("snapshot did not capture the counters");

	property p_snap_read;
		setup && sel == SEL_MIN && r.snap_en
			|=> r.prdata == {25'h0000000, $past(r.buf_min)};
	endproperty
	a_snap_read: assert property (p_snap_read)
		else $error("minutes read bypassed the snapshot");

	property p_snap_counts;
		r.snap_en && tick && !r.hold && !next_r.srst |=> r.inc;
	endproperty
	a_snap_counts: assert property (p_snap_counts)
		else $error("snapshot stopped the counters");

	property p_soft_reset;
		r.srst |-> !r.snap_en && !r.hold && !busy && !r.fmt24;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset left a control bit set");

	property p_reserved;
		setup && (sel == SEL_SEC || sel == SEL_MIN)
			|=> r.prdata[31:7] == 25'h0000000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits read non-zero");

	property p_answer;
		setup |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("bus answer not in the access cycle");

	property p_hold_taken;
		hold_req && !busy && !start && !r.srst |=> r.hold && !busy;
	endproperty
	a_hold_taken: assert property (p_hold_taken)
		else $error("hold refused while the counters were idle");

	property p_snap_keeps;
		r.snap_en |=> $stable(r.buf_sec) && $stable(r.buf_min)
			&& $stable(r.buf_hour);
	endproperty
	a_snap_keeps: assert property (p_snap_keeps)
		else $error("snapshot buffer changed while presented");

	property p_fmt_sel;
		acc_wr && sel == SEL_CTRL0 && !pwdata[SRST_BIT]
			|=> r.fmt24 == $past(pwdata[FMT_BIT]);
	endproperty
	a_fmt_sel: assert property (p_fmt_sel)
		else $error("hour format select missed the written value");

	property p_sec_step;
		r.inc && !r.wr[WR_SEC] && tif.sec[3:0] < UNITS_LAST
			|=> tif.sec[3:0] == $past(tif.sec[3:0]) + 4'h1;
	endproperty
	a_sec_step: assert property (p_sec_step)
		else $error("seconds units did not step on the carry");

endmodule

// ==== tb/rtcth_tb_top.sv ====
// Self-checking testbench for the time-of-day counter block.
`timescale 1ns/1ps
module rtcth_tb_top
	import rtcth_pkg::*;
;
	// ==========================================================
	// Settings and signals
	// Short periods keep the run small; every expectation follows them.
	localparam int unsigned SEC_P  = 200;
	localparam int unsigned BUSY_P = 20;
	localparam int unsigned TMO    = 20000;
	localparam logic [APB_AW-1:0] A_CTRL0 = {IDX_CTRL0[14:0], 2'h0};
	localparam logic [APB_AW-1:0] A_CTRL1 = {IDX_CTRL1[14:0], 2'h0};
	localparam logic [APB_AW-1:0] A_SEC   = {IDX_SEC[14:0], 2'h0};
	localparam logic [APB_AW-1:0] A_MIN   = {IDX_MIN[14:0], 2'h0};
	localparam logic [APB_AW-1:0] A_HOUR  = {IDX_HOUR[14:0], 2'h0};
	localparam logic [APB_AW-1:0] A_NONE  = A_HOUR + 17'h00004;

	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [APB_AW-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [31:0]       rd;
	logic              er;
	int                err_count;
	int                compares;
	int                cycles = 0;

	rtcth_top #(.SEC_PERIOD(SEC_P), .BUSY_PERIOD(BUSY_P)) u_dut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == TMO) begin
			err_count++;
			end_sim();
		end
	end

	// ==========================================================
	// Reporting
	task automatic end_sim();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// Bus access
	// The request stands until pready is seen high; the global
	// cycle limit is the only thing that ends a hung wait.
	task automatic apb(input logic w, input logic [APB_AW-1:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask

	task automatic rdc(input logic [APB_AW-1:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h00000000);
		chk_data(rd, {24'h000000, e});
	endtask

	task automatic wait_busy(input logic v);
		do begin
			apb(1'b0, A_CTRL1, 32'h00000000);
		end while (rd[BUSY_BIT] !== v);
	endtask

	// ==========================================================
	// Scenarios
	task automatic sc_reset();
		rdc(A_CTRL0, 8'h00);
		rdc(A_CTRL1, 8'h00);
		rdc(A_HOUR, 8'h00);
		apb(1'b1, A_NONE, 32'h000000FF);
		chk_bit(er, 1'b1);
		apb(1'b0, A_NONE, 32'h00000000);
		chk_bit(er, 1'b1);
		chk_data(rd, 32'h00000000);
	endtask

	// Loads a time under hold just after a carry, releases, and
	// checks the value after the next second; hour FF skips its write.
	task automatic tick_from(input logic [7:0] s, m, h, es, em, eh);
		wait_busy(1'b1);
		wait_busy(1'b0);
		wr(A_CTRL1, 8'h01);
		rdc(A_CTRL1, 8'h01);
		wr(A_SEC, s);
		wr(A_MIN, m);
		if (h !== 8'hFF) begin
			wr(A_HOUR, h);
		end
		rdc(A_SEC, s & 8'h7F);
		wr(A_CTRL1, 8'h00);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rdc(A_SEC, es);
		rdc(A_MIN, em);
		rdc(A_HOUR, eh);
	endtask

	task automatic sc_format();
		wr(A_CTRL0, 8'h10);
		rdc(A_CTRL0, 8'h10);
		rdc(A_HOUR, 8'h40);
		tick_from(8'h59, 8'h59, 8'hFF, 8'h00, 8'h00, 8'h01);
		tick_from(8'h59, 8'h59, 8'h23, 8'h00, 8'h00, 8'h00);
		tick_from(8'h59, 8'h59, 8'h09, 8'h00, 8'h00, 8'h10);
	endtask

	task automatic sc_snapshot();
		tick_from(8'h20, 8'h00, 8'h00, 8'h21, 8'h00, 8'h00);
		wr(A_CTRL1, 8'h04);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rdc(A_SEC, 8'h21);
		rdc(A_CTRL1, 8'h04);
		wr(A_CTRL1, 8'h00);
		rdc(A_SEC, 8'h22);
	endtask

	task automatic sc_hold();
		wait_busy(1'b1);
		wait_busy(1'b0);
		wr(A_CTRL1, 8'h01);
		wr(A_SEC, 8'h10);
		repeat (2 * SEC_P + 10) @(posedge pclk);
		rdc(A_SEC, 8'h10);
		rdc(A_CTRL1, 8'h01);
		wr(A_CTRL1, 8'h00);
		rdc(A_CTRL1, 8'h02);
		rdc(A_SEC, 8'h11);
	endtask

	task automatic sc_busy();
		wait_busy(1'b1);
		wr(A_CTRL1, 8'h01);
		rdc(A_CTRL1, 8'h02);
		repeat (BUSY_P + 2) @(posedge pclk);
		rdc(A_CTRL1, 8'h00);
	endtask

	task automatic sc_soft();
		wait_busy(1'b1);
		wait_busy(1'b0);
		wr(A_CTRL1, 8'h01);
		wr(A_SEC, 8'h37);
		wr(A_HOUR, 8'h11);
		wr(A_CTRL1, 8'h05);
		wr(A_CTRL0, 8'hFF);
		rdc(A_CTRL0, 8'h01);
		rdc(A_CTRL1, 8'h00);
		wr(A_CTRL0, 8'h00);
		rdc(A_CTRL0, 8'h00);
		rdc(A_CTRL1, 8'h00);
		rdc(A_SEC, 8'h37);
		rdc(A_HOUR, 8'h11);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = '0;
		pwdata    = '0;
		err_count = 0;
		compares  = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		sc_reset();
		tick_from(8'h59, 8'h59, 8'h51, 8'h00, 8'h00, 8'h00);
		tick_from(8'h59, 8'h59, 8'h49, 8'h00, 8'h00, 8'h50);
		tick_from(8'hD9, 8'h59, 8'h11, 8'h00, 8'h00, 8'h40);
		tick_from(8'h09, 8'h09, 8'h40, 8'h10, 8'h09, 8'h40);
		sc_format();
		sc_snapshot();
		sc_hold();
		sc_busy();
		sc_soft();
		end_sim();
	end

endmodule
